/* logic/esr_pkg.sv */
// Package: constants and carriers for the execution state and return payload unit
`default_nettype none
package esr_pkg;
   // Bus word offsets (byte addresses within the slave window)
   localparam logic [7:0] OFS_EXEC_STATUS = 8'h00;
   localparam logic [7:0] OFS_FAULT_MASK_S = 8'h04;
   localparam logic [7:0] OFS_FAULT_MASK_NS = 8'h08;
   localparam logic [7:0] OFS_FP_CTX_S = 8'h0c;
   localparam logic [7:0] OFS_FP_CTX_NS = 8'h10;
   localparam logic [7:0] OFS_PRIO_CTRL = 8'h14;
   localparam logic [7:0] OFS_EXEC_PRIO = 8'h18;
   localparam logic [7:0] OFS_FNC_PAYLOAD = 8'h1c;
   // Documented system addresses of the floating-point context address views
   localparam logic [31:0] FP_CTX_ADDR = 32'he000ef38;
   localparam logic [31:0] FP_CTX_NS_ADDR = 32'he002ef38;
   // Execution status field positions
   localparam int unsigned ISA_BIT = 24;
   localparam int unsigned CB_HI_MSB = 15;
   localparam int unsigned CB_HI_LSB = 10;
   localparam int unsigned CB_LO_MSB = 26;
   localparam int unsigned CB_LO_LSB = 25;
   // Return payload layout
   localparam logic [7:0] EXC_PREFIX = 8'hff;
   localparam logic [16:0] EXC_RES1 = 17'h1ffff;
   localparam int unsigned EXC_SEC_STACK_BIT = 6;
   localparam int unsigned EXC_DEFAULT_CALLEE_STACKING_BIT = 5;
   localparam int unsigned EXC_FRAME_TYPE_BIT_BIT = 4;
   localparam int unsigned EXC_MODE_BIT = 3;
   localparam int unsigned EXC_STACK_POINTER_CHOICE_BIT = 2;
   localparam int unsigned EXC_DOMAIN_BIT = 0;
   // Function payload: prefix byte, ones in 23:1, bit 0 set
   localparam logic [7:0] FNC_PREFIX = 8'hfe;
   localparam logic [22:0] FNC_ONES = 23'h7fffff;
   // Priority figures, 9-bit signed
   localparam logic signed [8:0] PRIO_NONE = 9'sh100;
   localparam logic signed [8:0] PRIO_ZERO = 9'sh000;
   localparam logic signed [8:0] PRIO_HALF = 9'sh080;
   localparam logic signed [8:0] PRIO_M1 = -9'sh001;
   localparam logic signed [8:0] PRIO_M3 = -9'sh003;
   // Reset values
   localparam logic [7:0] CB_RESET = 8'h00;
   localparam logic FM_RESET = 1'b0;
   localparam logic [31:0] BUS_ERR_DATA = 32'h00000000;

   // Fields captured at exception entry
   typedef struct packed {
      logic secure_stack;
      logic default_callee_stacking;
      logic frame_type_bit;
      logic thread_mode;
      logic stack_pointer_choice;
      logic exception_domain_bit;
   } esr_entry_t;
endpackage : esr_pkg
`default_nettype wire

/* logic/esr_core.sv */
// Execution state, fault priority mask and return payload unit
`default_nettype none
module esr_core #(
   parameter bit MAIN_EXT = 1'b1 // Main architectural extension present
) (
   input wire logic clock_i, // Core clock, 125 MHz
   input wire logic arst_n_i, // Asynchronous warm reset, active low
   // Avalon-MM slave
   input wire logic [7:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   output logic [1:0] avs_response_o,
   input wire logic bus_priv_i, // Access is privileged
   input wire logic bus_secure_i, // Access from secure software
   output logic bus_fault_b_o, // One-cycle bus fault pulse
   // Sequencer side
   input wire logic exc_entry_i, // Exception entry pulse
   input wire esr_pkg::esr_entry_t entry_info_i, // Fields of the frame
   input wire logic exception_return_payload_i, // Exception return pulse
   input wire logic [31:0] return_target_i, // Value branched to
   input wire logic signed [8:0] raw_prio_i, // Raw execution priority
   input wire logic secure_call_i, // Secure branch-with-link to nonsecure
   input wire logic instr_issue_i, // An instruction is decoded
   output logic [31:0] link_register_o, // Link register load value
   output logic link_load_o, // Link register load pulse
   output logic function_return_payload_o, // Branch to function payload seen
   output logic usage_fault_a_o, // Invalid state fault pulse
   output logic [7:0] conditional_block_state_o,
   output logic [7:0] continuable_instr_state_o,
   output logic signed [8:0] boost_prio_o // Boosted priority, 0x100 none
);
   // Execution status bits
   logic isa_reg;
   logic [7:0] cb_reg; // Stored in conditional-block order
   // Banked fault masks
   logic fm_s_reg;
   logic fm_ns_reg;
   // Priority control bits
   logic split_reg;
   logic nsfault_reg;
   // Banked context addresses, upper 29 bits
   logic [28:0] fpca_s_reg;
   logic [28:0] fpca_ns_reg;
   // Bus answer state
   logic ack_reg;
   logic [31:0] rdata_reg;
   logic [1:0] resp_reg;
   logic fault_reg;
   logic [31:0] lr_reg;
   logic lr_ld_reg;
   logic fnc_reg;
   logic uf_reg;
   logic [31:0] exc_payload;
   logic [31:0] fnc_payload;
   logic signed [8:0] boost;
   logic req;
   logic take;
   logic access_ok;
   logic wr_ok;
   logic is_ret;
   logic ret_domain;

   // One-wait-state slave: answer in the cycle after the request
   assign req = avs_read_i | avs_write_i;
   assign take = req & ack_reg;
   assign avs_waitrequest_o = req & ~ack_reg;
   assign avs_readdata_o = rdata_reg;
   assign avs_response_o = resp_reg;
   assign bus_fault_b_o = fault_reg;
   assign wr_ok = take & avs_write_i & bus_priv_i;

   // Exception payload assembly
   always_comb
   begin
      exc_payload = {esr_pkg::EXC_PREFIX, esr_pkg::EXC_RES1, 7'h00};
      exc_payload[esr_pkg::EXC_SEC_STACK_BIT] = entry_info_i.secure_stack;
      exc_payload[esr_pkg::EXC_DEFAULT_CALLEE_STACKING_BIT] = entry_info_i.default_callee_stacking;
      exc_payload[esr_pkg::EXC_FRAME_TYPE_BIT_BIT] = entry_info_i.frame_type_bit;
      exc_payload[esr_pkg::EXC_MODE_BIT] = entry_info_i.thread_mode;
      exc_payload[esr_pkg::EXC_STACK_POINTER_CHOICE_BIT] = entry_info_i.stack_pointer_choice;
      exc_payload[esr_pkg::EXC_DOMAIN_BIT] = entry_info_i.exception_domain_bit;
   end

   // Function payload: prefix, ones, bit 0 set
   assign fnc_payload = {esr_pkg::FNC_PREFIX, esr_pkg::FNC_ONES, 1'b1};

   // Return target decode; bit 0 of a function payload is ignored
   assign is_ret = return_target_i[31:24] == esr_pkg::EXC_PREFIX;
   assign ret_domain = return_target_i[esr_pkg::EXC_DOMAIN_BIT];

   // Link register loads
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         lr_reg <= 32'h00000000;
         lr_ld_reg <= 1'b0;
         fnc_reg <= 1'b0;
      end
      else
      begin
         lr_ld_reg <= exc_entry_i | secure_call_i;
         fnc_reg <= exception_return_payload_i & (return_target_i[31:1] == fnc_payload[31:1]);
         if (exc_entry_i)
         begin
            lr_reg <= exc_payload;
         end
         else if (secure_call_i)
         begin
            lr_reg <= fnc_payload;
         end
      end
   end
   assign link_register_o = lr_reg;
   assign link_load_o = lr_ld_reg;
   assign function_return_payload_o = fnc_reg;

   // Invalid state fault on issue with instruction-set bit clear
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         uf_reg <= 1'b0;
      end
      else
      begin
         uf_reg <= instr_issue_i & ~isa_reg;
      end
   end
   assign usage_fault_a_o = uf_reg;

   // Execution status register writes
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         isa_reg <= 1'b0; // Undefined at reset; zero chosen
         cb_reg <= esr_pkg::CB_RESET;
      end
      else if (wr_ok && avs_address_i == esr_pkg::OFS_EXEC_STATUS)
      begin
         isa_reg <= avs_writedata_i[esr_pkg::ISA_BIT];
         if (MAIN_EXT)
         begin
            cb_reg <= {avs_writedata_i[esr_pkg::CB_HI_MSB:esr_pkg::CB_HI_LSB],
                       avs_writedata_i[esr_pkg::CB_LO_MSB:esr_pkg::CB_LO_LSB]};
         end
      end
   end
   // Two views of the same bits; zero without main extension
   assign conditional_block_state_o = MAIN_EXT ? cb_reg : 8'h00;
   assign continuable_instr_state_o = MAIN_EXT ? {cb_reg[1:0], cb_reg[7:2]} : 8'h00;

   // Priority control bits
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         split_reg <= 1'b0;
         nsfault_reg <= 1'b0;
      end
      else if (wr_ok && bus_secure_i && avs_address_i == esr_pkg::OFS_PRIO_CTRL)
      begin
         split_reg <= avs_writedata_i[0];
         nsfault_reg <= avs_writedata_i[1];
      end
   end

   // Banked fault masks; return clear takes priority over a same-cycle write
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         fm_s_reg <= esr_pkg::FM_RESET;
         fm_ns_reg <= esr_pkg::FM_RESET;
      end
      else if (MAIN_EXT)
      begin
         if (wr_ok && bus_secure_i && avs_address_i == esr_pkg::OFS_FAULT_MASK_S)
         begin
            fm_s_reg <= avs_writedata_i[0];
         end
         if (wr_ok && avs_address_i == esr_pkg::OFS_FAULT_MASK_NS)
         begin
            fm_ns_reg <= avs_writedata_i[0];
         end
         if (exception_return_payload_i && is_ret && raw_prio_i >= esr_pkg::PRIO_ZERO)
         begin
            if (ret_domain)
            begin
               fm_s_reg <= 1'b0;
            end
            else
            begin
               fm_ns_reg <= 1'b0;
            end
         end
      end
   end

   // Priority boost; the strongest applicable boost wins
   always_comb
   begin
      boost = esr_pkg::PRIO_NONE;
      if (!nsfault_reg)
      begin
         if (fm_s_reg)
         begin
            boost = esr_pkg::PRIO_M1;
         end
         else if (fm_ns_reg)
         begin
            boost = split_reg ? esr_pkg::PRIO_HALF : esr_pkg::PRIO_ZERO;
         end
      end
      else
      begin
         if (fm_s_reg)
         begin
            boost = esr_pkg::PRIO_M3;
         end
         else if (fm_ns_reg)
         begin
            boost = esr_pkg::PRIO_M1;
         end
      end
   end
   assign boost_prio_o = boost;

   // Access permission: privileged, full word, alias only for secure
   always_comb
   begin
      access_ok = bus_priv_i && avs_byteenable_i == 4'hf;
      if (avs_address_i == esr_pkg::OFS_FP_CTX_NS && !bus_secure_i)
      begin
         access_ok = 1'b0;
      end
   end

   // Context address registers, low bits never stored
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         fpca_s_reg <= 29'h00000000; // Undefined at reset; zero chosen
         fpca_ns_reg <= 29'h00000000;
      end
      else if (take && avs_write_i && access_ok)
      begin
         if (avs_address_i == esr_pkg::OFS_FP_CTX_S)
         begin
            if (bus_secure_i)
            begin
               fpca_s_reg <= avs_writedata_i[31:3];
            end
            else
            begin
               fpca_ns_reg <= avs_writedata_i[31:3];
            end
         end
         else if (avs_address_i == esr_pkg::OFS_FP_CTX_NS)
         begin
            fpca_ns_reg <= avs_writedata_i[31:3];
         end
      end
   end

   // Bus answer: wait one cycle, then read data and response
   always_ff @(posedge clock_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         ack_reg <= 1'b0;
         rdata_reg <= esr_pkg::BUS_ERR_DATA;
         resp_reg <= 2'h0;
         fault_reg <= 1'b0;
      end
      else
      begin
         ack_reg <= req & ~ack_reg;
         fault_reg <= 1'b0;
         if (req && !ack_reg)
         begin
            rdata_reg <= 32'h00000000;
            resp_reg <= 2'h0;
            unique case (avs_address_i)
               esr_pkg::OFS_EXEC_STATUS:
               begin
                  if (bus_priv_i)
                  begin
                     rdata_reg[esr_pkg::ISA_BIT] <= isa_reg;
                     rdata_reg[esr_pkg::CB_HI_MSB:esr_pkg::CB_HI_LSB] <=
                        conditional_block_state_o[7:2];
                     rdata_reg[esr_pkg::CB_LO_MSB:esr_pkg::CB_LO_LSB] <=
                        conditional_block_state_o[1:0];
                  end
               end
               esr_pkg::OFS_FAULT_MASK_S:
               begin
                  rdata_reg[0] <= bus_priv_i & bus_secure_i & fm_s_reg;
               end
               esr_pkg::OFS_FAULT_MASK_NS:
               begin
                  rdata_reg[0] <= bus_priv_i & fm_ns_reg;
               end
               esr_pkg::OFS_FP_CTX_S, esr_pkg::OFS_FP_CTX_NS:
               begin
                  if (!access_ok)
                  begin
                     resp_reg <= 2'h2;
                     fault_reg <= 1'b1;
                  end
                  else if (avs_address_i == esr_pkg::OFS_FP_CTX_S && bus_secure_i)
                  begin
                     rdata_reg <= {fpca_s_reg, 3'h0};
                  end
                  else
                  begin
                     rdata_reg <= {fpca_ns_reg, 3'h0};
                  end
               end
               esr_pkg::OFS_PRIO_CTRL:
               begin
                  rdata_reg[1:0] <= {nsfault_reg, split_reg};
               end
               esr_pkg::OFS_EXEC_PRIO:
               begin
                  rdata_reg[8:0] <= boost;
               end
               esr_pkg::OFS_FNC_PAYLOAD:
               begin
                  rdata_reg <= fnc_payload;
               end
               default:
               begin
                  resp_reg <= 2'h2; // Unmapped: slave error
               end
            endcase
         end
      end
   end

   // Boost tied to mask bits and control
   chk_boost_ns_zero: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!nsfault_reg && !split_reg && fm_ns_reg && !fm_s_reg) |-> boost_prio_o == 9'sh000)
      else $error("Nonsecure mask boost not zero");
   chk_boost_ns_half: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (!nsfault_reg && split_reg && fm_ns_reg && !fm_s_reg) |-> boost_prio_o == 9'sh080)
      else $error("Split boost not 0x80");
   chk_boost_secure: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (nsfault_reg && fm_s_reg) |-> boost_prio_o == -9'sh003)
      else $error("Secure boost not minus three");
   // Payload on the link register one cycle after entry
   sequence entry_seq;
      exc_entry_i ##1 link_load_o;
   endsequence
   chk_entry_payload: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      entry_seq |-> link_register_o[31:7] == 25'h1ffffff && !link_register_o[1])
      else $error("Exception payload prefix wrong");
   chk_entry_domain: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      exc_entry_i |=> link_register_o[0] == $past(entry_info_i.exception_domain_bit))
      else $error("Payload domain bit wrong");
   chk_fnc_payload: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (secure_call_i && !exc_entry_i) |=> link_register_o == 32'hfeffffff)
      else $error("Function payload wrong");
   chk_return_clear: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (exception_return_payload_i && is_ret && raw_prio_i >= 9'sh000 && !ret_domain) |=> !fm_ns_reg)
      else $error("Mask not cleared on return");
   chk_invalid_state: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      (instr_issue_i && !isa_reg) |=> usage_fault_a_o)
      else $error("Missing invalid state fault");
   chk_fault_resp: assert property (@(posedge clock_i) disable iff (!arst_n_i)
      bus_fault_b_o |-> avs_response_o == 2'h2 && !avs_waitrequest_o)
      else $error("Bus fault without error response");
endmodule : esr_core
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the execution state and return payload unit
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Stimulus into the unit
   logic clock_i = 1'b0, arst_n_i = 1'b0, avs_read_i = 1'b0, avs_write_i = 1'b0;
   logic bus_priv_i = 1'b1, bus_secure_i = 1'b1, exc_entry_i = 1'b0, exception_return_payload_i = 1'b0;
   logic secure_call_i = 1'b0, instr_issue_i = 1'b0;
   logic [7:0] avs_address_i = 8'h00;
   logic [31:0] avs_writedata_i = 32'h0, return_target_i = 32'h0;
   logic [3:0] avs_byteenable_i = 4'hf;
   esr_pkg::esr_entry_t entry_info_i = '0;
   logic signed [8:0] raw_prio_i = 9'sh000;
   // Outputs of the unit
   logic [31:0] avs_readdata_o, link_register_o;
   logic avs_waitrequest_o, bus_fault_b_o, link_load_o, function_return_payload_o, usage_fault_a_o;
   logic [1:0] avs_response_o;
   logic [7:0] conditional_block_state_o, continuable_instr_state_o;
   logic signed [8:0] boost_prio_o;
   logic [7:0] x_cond, x_cont; // Field views of the variant without main extension
   // Bookkeeping and reference model state
   int bad_count = 0, checks = 0, cyc = 0;
   int m_s = 0, m_ns = 0, m_split = 0, m_nfh = 0;
   logic [31:0] rd, d, e32;
   logic [1:0] rsp;
   logic flt;
   logic [31:0] lr_q[$]; // Expected link register loads

   esr_core dut (
      .clock_i(clock_i), .arst_n_i(arst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
      .avs_response_o(avs_response_o), .bus_priv_i(bus_priv_i),
      .bus_secure_i(bus_secure_i), .bus_fault_b_o(bus_fault_b_o),
      .exc_entry_i(exc_entry_i), .entry_info_i(entry_info_i),
      .exception_return_payload_i(exception_return_payload_i), .return_target_i(return_target_i),
      .raw_prio_i(raw_prio_i), .secure_call_i(secure_call_i),
      .instr_issue_i(instr_issue_i), .link_register_o(link_register_o),
      .link_load_o(link_load_o), .function_return_payload_o(function_return_payload_o),
      .usage_fault_a_o(usage_fault_a_o),
      .conditional_block_state_o(conditional_block_state_o),
      .continuable_instr_state_o(continuable_instr_state_o),
      .boost_prio_o(boost_prio_o)
   );

   // Variant without the main extension; its field must stay zero
   esr_core #(.MAIN_EXT(1'b0)) dut_noext (
      .clock_i(clock_i), .arst_n_i(arst_n_i),
      .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
      .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
      .avs_readdata_o(), .avs_waitrequest_o(), .avs_response_o(), .bus_priv_i(bus_priv_i),
      .bus_secure_i(bus_secure_i), .bus_fault_b_o(),
      .exc_entry_i(exc_entry_i), .entry_info_i(entry_info_i),
      .exception_return_payload_i(exception_return_payload_i), .return_target_i(return_target_i),
      .raw_prio_i(raw_prio_i), .secure_call_i(secure_call_i),
      .instr_issue_i(instr_issue_i), .link_register_o(), .link_load_o(), .function_return_payload_o(),
      .usage_fault_a_o(), .conditional_block_state_o(x_cond),
      .continuable_instr_state_o(x_cont), .boost_prio_o()
   );

   // Core clock, 8 ns period
   always #4 clock_i = ~clock_i;

   // Hang guard on the whole run
   always @(posedge clock_i)
   begin
      cyc <= cyc + 1;
      if (cyc == 6000)
      begin
         bad_count++;
         $display("[FAIL] %0t run timed out", $time);
         print_verdict();
      end
   end

   // Counts, verdict and end of run
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : print_verdict

   // One comparison
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // One Avalon-MM transfer, held until waitrequest is low
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      input logic [3:0] be, input logic pv, input logic sc);
      @(posedge clock_i);
      avs_address_i <= a;
      avs_write_i <= w;
      avs_read_i <= ~w;
      avs_writedata_i <= wd;
      avs_byteenable_i <= be;
      bus_priv_i <= pv;
      bus_secure_i <= sc;
      // Hold until the rising edge that samples waitrequest low
      @(posedge clock_i);
      while (avs_waitrequest_o !== 1'b0)
         @(posedge clock_i);
      rd = avs_readdata_o;
      rsp = avs_response_o;
      flt = bus_fault_b_o;
      avs_read_i <= 1'b0;
      avs_write_i <= 1'b0;
      // Let the write settle before outputs are looked at
      @(negedge clock_i);
   endtask : bus

   // Privileged full-word write
   task automatic wr(input logic [7:0] a, input logic [31:0] wd, input logic sc);
      bus(1'b1, a, wd, 4'hf, 1'b1, sc);
   endtask : wr

   // Full-word read compared with the model
   task automatic rc(input logic [7:0] a, input logic pv, input logic sc, input logic [31:0] e);
      bus(1'b0, a, 32'h0, 4'hf, pv, sc);
      chk(rd, e, "read data");
   endtask : rc

   // Fault answer of the last transfer
   task automatic fault_chk(input logic f);
      chk({30'h0, rsp}, 32'h2, "response");
      chk({31'h0, flt}, {31'h0, f}, "bus fault");
   endtask : fault_chk

   // One-cycle sequencer pulse: 0 entry, 1 return, 2 secure call, 3 issue
   task automatic pulse(input int k);
      @(posedge clock_i);
      case (k)
         0: exc_entry_i <= 1'b1;
         1: exception_return_payload_i <= 1'b1;
         2: secure_call_i <= 1'b1;
         default: instr_issue_i <= 1'b1;
      endcase
      @(posedge clock_i);
      exc_entry_i <= 1'b0;
      exception_return_payload_i <= 1'b0;
      secure_call_i <= 1'b0;
      instr_issue_i <= 1'b0;
      @(negedge clock_i);
   endtask : pulse

   // Priority boost expected from the model
   function automatic logic [31:0] exp_boost();
      logic [8:0] b;
      b = 9'h100;
      if (m_ns != 0)
         b = (m_nfh != 0) ? 9'h1ff : ((m_split != 0) ? 9'h080 : 9'h000);
      if (m_s != 0)
         b = (m_nfh != 0) ? 9'h1fd : 9'h1ff;
      return {23'h0, b};
   endfunction : exp_boost

   // Main sequence
   initial
   begin
      void'($urandom(32'h5a5b));
      repeat (20) @(posedge clock_i);
      arst_n_i <= 1'b1;
      // Reset state
      rc(8'h00, 1'b1, 1'b1, 32'h0);
      rc(8'h04, 1'b1, 1'b1, 32'h0);
      chk({23'h0, boost_prio_o}, exp_boost(), "boost");
      rc(8'h1c, 1'b1, 1'b1, 32'hfeffffff);
      $display("test reset done");
      // Status fields, split orders and instruction-set bit
      for (int i = 0; i < 4; i++)
      begin
         d = $urandom;
         d[24] = i[0];
         wr(8'h00, d, 1'b1);
         e32 = d & 32'h0700fc00;
         rc(8'h00, 1'b1, 1'b1, e32);
         chk({24'h0, conditional_block_state_o}, {24'h0, d[15:10], d[26:25]}, "cond");
         chk({24'h0, continuable_instr_state_o}, {24'h0, d[26:25], d[15:10]}, "cont");
         chk({16'h0, x_cond, x_cont}, 32'h0, "no ext field");
         pulse(3);
         chk({31'h0, usage_fault_a_o}, {31'h0, ~d[24]}, "usage fault");
         bus(1'b1, 8'h00, ~d, 4'hf, 1'b0, 1'b1);
         rc(8'h00, 1'b0, 1'b1, 32'h0);
         rc(8'h00, 1'b1, 1'b1, e32);
      end
      $display("test status done");
      // Exception entry payloads
      for (int i = 0; i < 6; i++)
      begin
         @(posedge clock_i);
         entry_info_i <= esr_pkg::esr_entry_t'(6'($urandom));
         pulse(0);
         lr_q.push_back({8'hff, 17'h1ffff, entry_info_i[5:1], 1'b0, entry_info_i[0]});
         chk({31'h0, link_load_o}, 32'h1, "lr load");
         chk(link_register_o, lr_q.pop_front(), "exc payload");
      end
      $display("test entry done");
      // Boost for every control setting and mask pair
      for (int c = 0; c < 4; c++)
      begin
         for (int m = 0; m < 4; m++)
         begin
            m_split = c % 2;
            m_nfh = c / 2;
            m_s = m % 2;
            m_ns = m / 2;
            wr(8'h14, 32'(c), 1'b1);
            wr(8'h04, 32'($urandom << 1) | 32'(m_s), 1'b1);
            wr(8'h08, 32'($urandom << 1) | 32'(m_ns), 1'b0);
            chk({23'h0, boost_prio_o}, exp_boost(), "boost");
            rc(8'h08, 1'b1, 1'b1, 32'(m_ns));
            rc(8'h04, 1'b0, 1'b1, 32'h0);
         end
      end
      bus(1'b1, 8'h08, 32'h0, 4'hf, 1'b0, 1'b0);
      rc(8'h08, 1'b1, 1'b0, 32'(m_ns));
      $display("test boost done");
      // Return clears the mask of the payload domain only from priority zero or above
      for (int i = 0; i < 4; i++)
      begin
         m_s = 1;
         m_ns = 1;
         wr(8'h04, 32'h1, 1'b1);
         wr(8'h08, 32'h1, 1'b1);
         @(posedge clock_i);
         raw_prio_i <= (i < 2) ? 9'sh000 : -9'sh001;
         return_target_i <= 32'hffffff20 | 32'(i % 2);
         pulse(1);
         chk({31'h0, function_return_payload_o}, 32'h0, "function_return_payload");
         if (i == 0)
            m_ns = 0;
         if (i == 1)
            m_s = 0;
         rc(8'h04, 1'b1, 1'b1, 32'(m_s));
         rc(8'h08, 1'b1, 1'b1, 32'(m_ns));
      end
      pulse(2);
      chk({31'h0, link_load_o}, 32'h1, "lr load");
      chk(link_register_o, 32'hfeffffff, "fnc payload");
      @(posedge clock_i);
      return_target_i <= 32'hfefffffe;
      pulse(1);
      chk({31'h0, function_return_payload_o}, 32'h1, "function_return_payload");
      $display("test return done");
      // Banked context address and its faults
      d = $urandom;
      e32 = $urandom;
      wr(8'h0c, d, 1'b1);
      wr(8'h0c, e32, 1'b0);
      rc(8'h0c, 1'b1, 1'b1, d & 32'hfffffff8);
      rc(8'h10, 1'b1, 1'b1, e32 & 32'hfffffff8);
      rc(8'h0c, 1'b1, 1'b0, e32 & 32'hfffffff8);
      bus(1'b0, 8'h10, 32'h0, 4'hf, 1'b1, 1'b0);
      fault_chk(1'b1);
      bus(1'b0, 8'h0c, 32'h0, 4'hf, 1'b0, 1'b1);
      fault_chk(1'b1);
      bus(1'b1, 8'h0c, ~d, 4'h3, 1'b1, 1'b1);
      fault_chk(1'b1);
      rc(8'h0c, 1'b1, 1'b1, d & 32'hfffffff8);
      bus(1'b0, 8'h40, 32'h0, 4'hf, 1'b1, 1'b1);
      fault_chk(1'b0);
      $display("test context done");
      // Warm reset in mid-run
      wr(8'h00, 32'h0700fc00, 1'b1);
      wr(8'h04, 32'h1, 1'b1);
      @(posedge clock_i);
      arst_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      arst_n_i <= 1'b1;
      m_s = 0;
      m_ns = 0;
      chk({24'h0, conditional_block_state_o}, 32'h0, "cond");
      rc(8'h04, 1'b1, 1'b1, 32'h0);
      chk({23'h0, boost_prio_o}, exp_boost(), "boost");
      $display("test warm reset done");
      print_verdict();
   end
endmodule : tb
`default_nettype wire
